//--- bench/eip_pins_model.sv
// port 0 pad model standing in front of the pin select block.
// assumes the bench asks for a pad pattern by non-blocking assignment.
`default_nettype none
module eip_pins_model (
  input wire logic clk_sys,
  input wire logic [7:0] want,
  output var logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 8'h00;
  // pads follow a request one clock late, as a real driver would; any pin may
  // toggle whatever else it serves, the block must still watch it
  always @(posedge clk_sys) begin
    pins <= want;
  end
endmodule
`default_nettype wire

//--- bench/eip_top_test.sv
// self-checking bench for eip_top: registers, pin routing, polarity, irq.
// assumes eip_pins_model drives the port pins one clock after a request.
`include "eip_defs.svh"
`default_nettype none
module eip_top_test
  import eip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  eip_addr_t addr = 8'h00;
  eip_byte_t wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  eip_byte_t rd_data;
  logic [7:0] want = 8'h00;
  logic [7:0] pins;
  logic ext1, prio_s, prio_v, irq;
  int miscompares = 0;
  int n_tests = 0;
  int cfg_m = 0;
  int prio_m = 0;
  int stat_m = 0;
  int trig_m = 0;
  int mask_m = 0;

  always #10 clk_sys = ~clk_sys;

  eip_top #(.NPINS(8)) u_eip_top (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .port0_pins(pins), .external_interrupt_one(ext1),
    .serial_port_two_priority(prio_s), .bus_voltage_irq_priority(prio_v), .irq(irq));
  eip_pins_model u_eip_pins_model (.clk_sys(clk_sys), .want(want), .pins(pins));

  // register image kept by the bench; unmapped places read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == `EIP_ADDR_PIN_CFG) return 8'(cfg_m);
    if (a == `EIP_ADDR_PRIO_TWO) return 8'(prio_m);
    if (a == `EIP_ADDR_IRQ_STAT) return 8'(stat_m);
    if (a == `EIP_ADDR_TRIG_CTL) return 8'(trig_m);
    if (a == `EIP_ADDR_IRQ_MASK) return 8'(mask_m);
    return 8'h00;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    if (a == `EIP_ADDR_PIN_CFG) cfg_m = d & 8'hF0;
    if (a == `EIP_ADDR_PRIO_TWO) prio_m = d & 8'h03;
    if (a == `EIP_ADDR_IRQ_STAT) stat_m = stat_m & ~d & 1;
    if (a == `EIP_ADDR_TRIG_CTL) trig_m = d & 1;
    if (a == `EIP_ADDR_IRQ_MASK) mask_m = d & 1;
  endtask

  // read data are only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rd_data, exp_rd(a));
  endtask

  // level mode: request follows the chosen pad, polarity corrected
  task automatic pin_chk(input logic [7:0] p);
    logic e;
    e = p[cfg_m[6:4]] ^ ~cfg_m[7];
    @(posedge clk_sys);
    want <= p;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(8'(ext1), 8'(e));
  endtask

  task automatic test_done();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang is cut short long after the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    test_done();
  end

  initial begin
    logic [7:0] oh;
    void'($urandom(32'h7C437FC7));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`EIP_ADDR_PRIO_TWO);
    rd(`EIP_ADDR_PIN_CFG);
    rd(8'h10);
    rd(`EIP_ADDR_TRIG_CTL);
    rd(`EIP_ADDR_IRQ_MASK);
    for (int i = 0; i < 4; i++) begin
      wr(`EIP_ADDR_PRIO_TWO, 8'($urandom));
      rd(`EIP_ADDR_PRIO_TWO);
      chk({6'h00, prio_s, prio_v}, 8'(prio_m));
    end
    // every selector under both polarities, one-hot pads show the routing
    for (int s = 0; s < 16; s++) begin
      wr(`EIP_ADDR_PIN_CFG, {s[0], s[3:1], 4'hF});
      rd(`EIP_ADDR_PIN_CFG);
      oh = 8'h01 << s[3:1];
      pin_chk(oh);
      pin_chk(~oh);
      pin_chk(8'($urandom));
    end
    // edge mode from the separate trigger register, with status and mask
    @(posedge clk_sys);
    want <= 8'h00;
    wr(`EIP_ADDR_TRIG_CTL, 8'h01);
    rd(`EIP_ADDR_TRIG_CTL);
    wr(`EIP_ADDR_PIN_CFG, 8'hB0);
    wr(`EIP_ADDR_IRQ_STAT, 8'h01);
    wr(`EIP_ADDR_IRQ_MASK, 8'h01);
    rd(`EIP_ADDR_IRQ_MASK);
    rd(`EIP_ADDR_IRQ_STAT);
    @(posedge clk_sys);
    want <= 8'h08;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({ext1, irq}, 8'h03);
    @(posedge clk_sys);
    #1;
    chk({ext1, irq}, 8'h01);
    stat_m = 1;
    rd(`EIP_ADDR_IRQ_STAT);
    wr(`EIP_ADDR_IRQ_MASK, 8'h00);
    #1;
    chk(8'(irq), 8'h00);
    wr(`EIP_ADDR_IRQ_STAT, 8'h01);
    wr(`EIP_ADDR_IRQ_MASK, 8'h01);
    #1;
    chk(8'(irq), 8'h00);
    rd(`EIP_ADDR_IRQ_STAT);
    // back to level mode with the pin still active: the clear meets a live
    // event every cycle, so the set must win and the status stays up
    wr(`EIP_ADDR_TRIG_CTL, 8'h00);
    rd(`EIP_ADDR_TRIG_CTL);
    wr(`EIP_ADDR_IRQ_STAT, 8'h01);
    stat_m = 1;
    rd(`EIP_ADDR_IRQ_STAT);
    chk({ext1, irq}, 8'h03);
    test_done();
  end
endmodule
`default_nettype wire

//--- hdl/eip_pin_sel.sv
// selects one port 0 pin and applies the polarity setting.
// assumes pins are synchronous to the clock of the instantiating module.
`default_nettype none
module eip_pin_sel
  import eip_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic [NPINS-1:0] pins,
  input wire eip_sel_t sel,
  input wire logic pol_high,
  output logic active
);
  // the pin is read straight from the pad, never through the crossbar [R4]
  logic raw_pin;
  assign raw_pin = pins[sel]; // [R3]
  // polarity 1 passes the pin, polarity 0 inverts it [R2] [R6]
  assign active = pol_high ? raw_pin : ~raw_pin;
endmodule
`default_nettype wire

//--- hdl/eip_top.sv
// pin configuration, trigger control and extended priority registers for
// external interrupt one, with a sticky status, a mask and a level irq.
// assumes a one-cycle read/write strobe port and pins synchronous to clk_sys.
`include "eip_defs.svh"
`default_nettype none
module eip_top
  import eip_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire eip_addr_t addr,
  input wire eip_byte_t wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output eip_byte_t rd_data,
  input wire logic [NPINS-1:0] port0_pins,
  output logic external_interrupt_one,
  output logic serial_port_two_priority,
  output logic bus_voltage_irq_priority,
  output logic irq
);

  // register state
  logic ext_irq1_polarity_q;
  eip_sel_t ext_irq1_pin_selector_q;
  logic [1:0] prio_q;
  logic trig_edge_q;
  logic stat_q;
  logic mask_q;
  logic act_q;
  logic req_q;
  logic irq_q;
  eip_byte_t rd_data_q;

  // address decode
  logic hit_cfg;
  logic hit_prio;
  logic hit_trig;
  logic hit_stat;
  logic hit_mask;
  assign hit_cfg = (addr == `EIP_ADDR_PIN_CFG);
  assign hit_prio = (addr == `EIP_ADDR_PRIO_TWO);
  assign hit_trig = (addr == `EIP_ADDR_TRIG_CTL);
  assign hit_stat = (addr == `EIP_ADDR_IRQ_STAT);
  assign hit_mask = (addr == `EIP_ADDR_IRQ_MASK);

  logic wr_cfg;
  logic wr_prio;
  logic wr_trig;
  logic wr_stat;
  logic wr_mask;
  assign wr_cfg = wr_stb & hit_cfg;
  assign wr_prio = wr_stb & hit_prio;
  assign wr_trig = wr_stb & hit_trig;
  assign wr_stat = wr_stb & hit_stat;
  assign wr_mask = wr_stb & hit_mask;

  // selected pin after polarity, sampled straight off the port
  logic act_d;
  eip_pin_sel #(
    .NPINS(NPINS)
  ) u_pin_sel (
    .pins(port0_pins),
    .sel(ext_irq1_pin_selector_q),
    .pol_high(ext_irq1_polarity_q),
    .active(act_d)
  );

  // trigger style comes only from the trigger control register [R5]
  eip_trig_e trig_mode;
  assign trig_mode = trig_edge_q ? EIP_TRIG_EDGE : EIP_TRIG_LEVEL;

  // request toward the core: a level, or one pulse on the inactive-to-active step
  logic rise;
  logic req_d;
  assign rise = act_d & ~act_q;
  assign req_d = (trig_mode == EIP_TRIG_EDGE) ? rise : act_d; // [R5]

  // sticky event: a new event in the clearing cycle wins over the clear
  logic evt;
  logic stat_d;
  logic clr_stat;
  assign evt = req_d;
  assign clr_stat = wr_stat & wr_data[`EIP_EVT_ACT_BIT];
  assign stat_d = evt | (stat_q & ~clr_stat);

  // irq uses next-state values so it lines up with the status flop
  logic mask_d;
  logic irq_d;
  assign mask_d = wr_mask ? wr_data[`EIP_EVT_ACT_BIT] : mask_q;
  assign irq_d = stat_d & mask_d;

  // read mux; unmapped addresses and unused bits read as zero
  eip_byte_t rd_mux;
  assign rd_mux =
    hit_cfg ? {ext_irq1_polarity_q, ext_irq1_pin_selector_q, 4'h0} :
    hit_prio ? {6'h00, prio_q} :
    hit_trig ? {7'h00, trig_edge_q} :
    hit_stat ? {7'h00, stat_q} :
    hit_mask ? {7'h00, mask_q} : 8'h00;

  // pin configuration; the low nibble belongs to input zero and is not held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_irq1_polarity_q <= 1'b0;
      ext_irq1_pin_selector_q <= 3'h0;
    end else if (wr_cfg) begin
      ext_irq1_polarity_q <= wr_data[`EIP_CFG_POL_BIT]; // [R2] [R6]
      ext_irq1_pin_selector_q <= wr_data[`EIP_CFG_SEL_HI:`EIP_CFG_SEL_LO]; // [R3]
    end
  end

  // priority register, bits 7 to 2 are not stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prio_q <= 2'h0;
    end else if (wr_prio) begin
      prio_q <= wr_data[1:0]; // [R1]
    end
  end

  // trigger control and mask
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_edge_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      if (wr_trig) begin
        trig_edge_q <= wr_data[`EIP_TRIG_EDGE_BIT]; // [R5]
      end
      mask_q <= mask_d;
    end
  end

  // input tracking, request, status and interrupt line
  // a polarity or selector change can look like a fresh edge: software
  // should set edge mode only after the pin configuration is settled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_q <= 1'b0;
      req_q <= 1'b0;
      stat_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      act_q <= act_d;
      req_q <= req_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_stb ? rd_mux : 8'h00;
    end
  end

  assign rd_data = rd_data_q;
  assign external_interrupt_one = req_q;
  assign serial_port_two_priority = prio_q[`EIP_PRIO_UART_BIT]; // [R1]
  assign bus_voltage_irq_priority = prio_q[`EIP_PRIO_VBUS_BIT]; // [R1]
  assign irq = irq_q;

  // checks

  property p_prio_write;
    @(posedge clk_sys) disable iff (rst)
    wr_prio |=> (serial_port_two_priority == $past(wr_data[1]))
      && (bus_voltage_irq_priority == $past(wr_data[0]));
  endproperty
  a_prio_write: assert property (p_prio_write) // [R1]
    else $error("priority outputs do not follow the written value");

  property p_prio_hold;
    @(posedge clk_sys) disable iff (rst)
    !wr_prio |=> $stable({serial_port_two_priority, bus_voltage_irq_priority});
  endproperty
  a_prio_hold: assert property (p_prio_hold) // [R1]
    else $error("priority changed without a write");

  property p_level_high;
    @(posedge clk_sys) disable iff (rst)
    (!trig_edge_q && ext_irq1_polarity_q)
      |=> (external_interrupt_one == $past(port0_pins[ext_irq1_pin_selector_q]));
  endproperty
  a_level_high: assert property (p_level_high) // [R2]
    else $error("active high request does not follow the pin");

  property p_level_low;
    @(posedge clk_sys) disable iff (rst)
    (!trig_edge_q && !ext_irq1_polarity_q)
      |=> (external_interrupt_one == !$past(port0_pins[ext_irq1_pin_selector_q]));
  endproperty
  a_level_low: assert property (p_level_low) // [R6]
    else $error("active low request does not follow the inverted pin");

  property p_route;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (act_q == ($past(port0_pins[ext_irq1_pin_selector_q])
      ^ !$past(ext_irq1_polarity_q)));
  endproperty
  a_route: assert property (p_route) // [R3]
    else $error("tracked input is not the selected pin");

  property p_edge_pulse;
    @(posedge clk_sys) disable iff (rst)
    (trig_edge_q && act_d && !act_q)
      |=> external_interrupt_one ##1 (!external_interrupt_one || !$past(trig_edge_q));
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) // [R5]
    else $error("edge request is not a single pulse on activation");

  property p_edge_quiet;
    @(posedge clk_sys) disable iff (rst)
    (trig_edge_q && !(act_d && !act_q)) |=> !external_interrupt_one;
  endproperty
  a_edge_quiet: assert property (p_edge_quiet) // [R5]
    else $error("edge request without an activation step");

  property p_irq_path;
    @(posedge clk_sys) disable iff (rst)
    (req_d && mask_d) |=> (stat_q && irq) [*1] ##1 (irq || !stat_q || !mask_q);
  endproperty
  a_irq_path: assert property (p_irq_path)
    else $error("unmasked event did not raise the interrupt");

  property p_rd_once;
    @(posedge clk_sys) disable iff (rst)
    !rd_stb |=> (rd_data == 8'h00);
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data present without a read strobe");

  c_edge_req: cover property (@(posedge clk_sys) disable iff (rst)
    trig_edge_q && external_interrupt_one);
  c_level_low: cover property (@(posedge clk_sys) disable iff (rst)
    !ext_irq1_polarity_q && external_interrupt_one);
  c_pin7: cover property (@(posedge clk_sys) disable iff (rst)
    (ext_irq1_pin_selector_q == 3'h7) && act_q);
  c_clear_race: cover property (@(posedge clk_sys) disable iff (rst)
    clr_stat && evt);

endmodule
`default_nettype wire

//--- inc/eip_defs.svh
// register offsets, field positions and reset values for the
// external interrupt 1 pin select and extended priority block.
// assumes an 8-bit special function register address space.
//
// Overview of operation
// [R1] An 8-bit priority register has bit 1 for the second serial port priority and bit 0 for the bus-voltage interrupt priority, 0 meaning low and 1 meaning high.
// [R2] With the polarity bit (bit 7 of the pin configuration register) at 1, the selected input is active high.
// [R3] The 3-bit selector in bits 6 to 4 picks port 0 pin 0 to 7 as the external interrupt one input.
// [R4] The chosen pin is watched whatever the crossbar has assigned it to, so it may serve another peripheral too.
// [R5] Edge or level triggering comes from a separate control register, not from the pin configuration register.
// [R6] With the polarity bit at 0, the selected input is active low.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

// register addresses
`define EIP_ADDR_PIN_CFG 8'hE4
`define EIP_ADDR_PRIO_TWO 8'hF7
`define EIP_ADDR_TRIG_CTL 8'hC0
`define EIP_ADDR_IRQ_STAT 8'hC1
`define EIP_ADDR_IRQ_MASK 8'hC2

// pin configuration fields
`define EIP_CFG_POL_BIT 7
`define EIP_CFG_SEL_HI 6
`define EIP_CFG_SEL_LO 4
`define EIP_CFG_RESET 8'h00

// priority fields
`define EIP_PRIO_UART_BIT 1
`define EIP_PRIO_VBUS_BIT 0
`define EIP_PRIO_RESET 8'h00

// trigger control, status and mask fields
`define EIP_TRIG_EDGE_BIT 0
`define EIP_EVT_ACT_BIT 0
`define EIP_CTL_RESET 8'h00

`endif

//--- inc/eip_pkg.sv
// shared types for the external interrupt pin select block.
// assumes eip_defs.svh carries the numbers; this holds the types only.
`default_nettype none
package eip_pkg;
  typedef logic [7:0] eip_byte_t;
  typedef logic [7:0] eip_addr_t;
  typedef logic [2:0] eip_sel_t;
  // trigger style of the external interrupt one request
  typedef enum logic {EIP_TRIG_LEVEL, EIP_TRIG_EDGE} eip_trig_e;
endpackage
`default_nettype wire
